// ==== rtl/tfw_regs.svh ====
`ifndef TFW_REGS_SVH
`define TFW_REGS_SVH

// clock rate in MHz
`define TFW_CLK_MHZ        200
// temperature check period, ms
`define TFW_CHECK_MS       4000
// settle time of sink or bias before sampling, us
`define TFW_SETTLE_US      100
// least time regulator must be good before gates may close, us
`define TFW_PWRUP_US       1000
// sense code width; code is ratiometric, full scale = bias voltage
`define TFW_CODE_W         10
// thresholds as fractions of full scale (code / 1024)
`define TFW_TH_EXT_PU      10'h3E0
`define TFW_TH_OPEN        10'h3C0
`define TFW_TH_HOT         10'h100
`define TFW_TH_SHORT       10'h020

`endif

// ==== rtl/tfw_pkg.sv ====
package tfw_pkg;
	typedef enum logic [1:0] {
		TFW_SHUTDOWN,
		TFW_POWERUP,
		TFW_ACTIVE
	} tfw_state_t;

	typedef enum logic [1:0] {
		TFW_IDLE,
		TFW_PULL,
		TFW_BIAS
	} tfw_phase_t;

	typedef enum logic [1:0] {
		TFW_F_NONE,
		TFW_F_SHORT,
		TFW_F_OPEN,
		TFW_F_HOT
	} tfw_fault_t;
endpackage : tfw_pkg

// ==== rtl/tfw_sync_if.sv ====
`timescale 1ns/1ps
interface tfw_sync_if;
	logic charger;
	logic ret_low;
	logic reg_ok;
	modport src (output charger, output ret_low, output reg_ok);
	modport dst (input charger, input ret_low, input reg_ok);
endinterface : tfw_sync_if

// ==== rtl/tfw_sync.sv ====
`timescale 1ns/1ps
module tfw_sync (
	input  wire logic  clock,        // system clock
	input  wire logic  nrst,         // async reset, active low
	input  wire logic  charger_in,   // raw charger-sense comparator
	input  wire logic  ret_in,       // raw charger-return comparator
	input  wire logic  reg_ok_in,    // raw regulator-good
	tfw_sync_if.src    sync          // synchronised levels
);
	logic [2:0] stage1;
	logic [2:0] stage2;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 3'h0;
			stage2 <= 3'h0;
		end else begin
			stage1 <= {charger_in, ret_in, reg_ok_in};
			stage2 <= stage1;
		end
	end

	assign sync.charger = stage2[2];
	assign sync.ret_low = stage2[1];
	assign sync.reg_ok  = stage2[0];
endmodule : tfw_sync

// ==== rtl/tfw_top.sv ====
// Contract
// - shutdown turns regulator and circuitry off
// - regulator off forces both gates off
// - charger sense above 0.5 V means connected
// - charger sense always on, wakes from shutdown
// - woken device may shut down if faulted
// - low charger return wakes, not latched
// - bias driven only during temperature reads
// - weak sink; external pullup disables own bias
// - below hot: flag, gates off, stay active
// - open fault clears within one check
// - short: shutdown until charger reinserted
// - undertemperature acts as open, stays awake
// - thresholds are fractions of bias voltage
`timescale 1ns/1ps
`include "tfw_regs.svh"
module tfw_top #(
	parameter int unsigned CHECK_CYC  = `TFW_CHECK_MS * 1000 * `TFW_CLK_MHZ,
	parameter int unsigned SETTLE_CYC = `TFW_SETTLE_US * `TFW_CLK_MHZ,
	parameter int unsigned PWRUP_CYC  = `TFW_PWRUP_US * `TFW_CLK_MHZ
) (
	input  wire logic                   clock,                  // 200 MHz
	input  wire logic                   nrst,                   // async, active low
	input  wire logic                   charger_sense_input,    // sense above 0.5 V
	input  wire logic                   charger_return_input,   // return below ground - 2 V
	input  wire logic                   regulator_output,       // regulator good
	input  wire logic [`TFW_CODE_W-1:0] thermistor_sense_input, // sense code, same clock
	output logic                        regulator_enable,       // regulator on
	output logic                        discharge_gate_drive,   // discharge gate on
	output logic                        charge_gate_drive,      // charge gate on
	output logic                        thermistor_bias_output, // own bias on
	output logic                        sense_sink_enable,      // weak sink on sense pin
	output logic                        overtemp_flag,          // pack overtemperature
	output logic                        open_flag,              // open or undertemperature
	output logic                        short_flag,             // shorted thermistor seen
	output tfw_pkg::tfw_state_t         mode                    // current power mode
);
	import tfw_pkg::*;

	localparam logic [31:0] CHECK_LAST  = 32'(CHECK_CYC - 1);
	localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYC - 1);
	localparam logic [31:0] PWRUP_LAST  = 32'(PWRUP_CYC - 1);

	tfw_sync_if sync ();

	tfw_sync u_sync (
		.clock      (clock),
		.nrst       (nrst),
		.charger_in (charger_sense_input),
		.ret_in     (charger_return_input),
		.reg_ok_in  (regulator_output),
		.sync       (sync.src)
	);

	// short first, then open, then hot
	function automatic tfw_fault_t classify(input logic [`TFW_CODE_W-1:0] code);
		if (code < `TFW_TH_SHORT)
			return TFW_F_SHORT;
		else if (code > `TFW_TH_OPEN)
			return TFW_F_OPEN;
		else if (code < `TFW_TH_HOT)
			return TFW_F_HOT;
		else
			return TFW_F_NONE;
	endfunction : classify

	tfw_state_t  state;
	tfw_phase_t  phase;
	logic [31:0] timer;
	logic        cr_wake;
	logic        short_wait;
	tfw_state_t  next_state;
	tfw_phase_t  next_phase;
	logic [31:0] next_timer;
	logic        next_cr_wake;
	logic        next_short_wait;
	logic        next_overtemp;
	logic        next_open;
	logic        next_short;

	wire        chg_s      = sync.charger;
	wire        ret_s      = sync.ret_low;
	wire        rok_s      = sync.reg_ok;
	wire        settle_end = (timer >= SETTLE_LAST);
	wire        check_due  = (timer >= CHECK_LAST);
	wire        ext_pu     = (thermistor_sense_input > `TFW_TH_EXT_PU);
	wire        eval_now   = (phase == TFW_PULL && settle_end && ext_pu) ||
	                         (phase == TFW_BIAS && settle_end);
	wire tfw_fault_t fault = classify(thermistor_sense_input);
	// wake by return input lasts only while it is held
	wire        cr_lost    = cr_wake && !ret_s;
	wire        next_gates = (next_state == TFW_ACTIVE) && rok_s && !next_open && !next_overtemp;

	always_comb begin
		next_state      = state;
		next_phase      = phase;
		next_timer      = timer + 32'h1;
		next_cr_wake    = cr_wake;
		next_short_wait = short_wait;
		next_overtemp   = overtemp_flag;
		next_open       = open_flag;
		next_short      = short_flag;
		unique case (state)
			TFW_SHUTDOWN: begin
				next_phase = TFW_IDLE;
				next_timer = 32'h0;
				// charger must go away before it can wake again
				if (!chg_s)
					next_short_wait = 1'b0;
				if (chg_s && !short_wait) begin
					next_state   = TFW_POWERUP;
					next_cr_wake = 1'b0;
				end else if (ret_s && !short_wait) begin
					next_state   = TFW_POWERUP;
					next_cr_wake = 1'b1;
				end
			end
			TFW_POWERUP: begin
				next_phase = TFW_IDLE;
				if (cr_lost) begin
					next_state = TFW_SHUTDOWN;
				end else if (!rok_s) begin
					next_timer = 32'h0;
				end else if (timer >= PWRUP_LAST) begin
					next_state    = TFW_ACTIVE;
					next_timer    = 32'h0;
					next_overtemp = 1'b0;
					next_open     = 1'b0;
					next_short    = 1'b0;
				end
			end
			TFW_ACTIVE: begin
				if (chg_s)
					next_cr_wake = 1'b0;
				if (cr_lost) begin
					next_state = TFW_SHUTDOWN;
					next_phase = TFW_IDLE;
				end else begin
					unique case (phase)
						TFW_IDLE: if (check_due) begin
							next_phase = TFW_PULL;
							next_timer = 32'h0;
						end
						TFW_PULL: if (settle_end && !ext_pu) begin
							// own bias only for this read
							next_phase = TFW_BIAS;
							next_timer = 32'h0;
						end
						TFW_BIAS: ;
						default: next_phase = TFW_IDLE;
					endcase
					if (eval_now) begin
						next_phase = TFW_IDLE;
						next_timer = 32'h0;
						// a clean read clears open fault
						next_open     = (fault == TFW_F_OPEN);
						next_overtemp = (fault == TFW_F_HOT);
						if (fault == TFW_F_SHORT) begin
							// a woken pack with short sleeps again
							next_short      = 1'b1;
							next_short_wait = 1'b1;
							next_state      = TFW_SHUTDOWN;
						end
					end
				end
			end
			// unused code: fall back to the safe, regulator-off state
			default: begin
				next_state = TFW_SHUTDOWN;
				next_phase = TFW_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state       <= TFW_SHUTDOWN;
			phase       <= TFW_IDLE;
			timer       <= 32'h0;
			cr_wake     <= 1'b0;
			short_wait  <= 1'b0;
		end else begin
			state       <= next_state;
			phase       <= next_phase;
			timer       <= next_timer;
			cr_wake     <= next_cr_wake;
			short_wait  <= next_short_wait;
		end
	end

	// outputs registered from next values so they track state exactly
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			regulator_enable       <= 1'b0;
			discharge_gate_drive   <= 1'b0;
			charge_gate_drive      <= 1'b0;
			thermistor_bias_output <= 1'b0;
			sense_sink_enable      <= 1'b0;
			overtemp_flag          <= 1'b0;
			open_flag              <= 1'b0;
			short_flag             <= 1'b0;
			mode                   <= TFW_SHUTDOWN;
		end else begin
			regulator_enable       <= (next_state != TFW_SHUTDOWN);
			// gates only with a good regulator
			// open and hot faults open gates, device stays awake; a short shuts it down
			discharge_gate_drive   <= next_gates;
			charge_gate_drive      <= next_gates;
			// bias pulsed only in the read phase
			thermistor_bias_output <= (next_phase == TFW_BIAS);
			// weak sink for the whole check
			sense_sink_enable      <= (next_phase != TFW_IDLE);
			overtemp_flag          <= next_overtemp;
			open_flag              <= next_open;
			short_flag             <= next_short;
			mode                   <= next_state;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_gates_off_down: assert property (
		(mode == TFW_SHUTDOWN) |-> !regulator_enable && !discharge_gate_drive && !charge_gate_drive
	) else $error("gates or regulator on in shutdown");

	a_gates_need_reg: assert property (
		!rok_s |=> !discharge_gate_drive && !charge_gate_drive
	) else $error("gates on without regulator");

	a_charger_wakes: assert property (
		(state == TFW_SHUTDOWN && chg_s && !short_wait) |=> mode == TFW_POWERUP
	) else $error("charger did not wake device");

	a_return_unlatched: assert property (
		(state != TFW_SHUTDOWN && cr_wake && !ret_s) |=> mode == TFW_SHUTDOWN
	) else $error("return wake held after release");

	a_bias_in_read: assert property (
		thermistor_bias_output |-> phase == TFW_BIAS && sense_sink_enable
	) else $error("bias on outside a reading");

	a_ext_no_bias: assert property (
		(state == TFW_ACTIVE && phase == TFW_PULL && settle_end && ext_pu && !cr_lost)
		|=> !thermistor_bias_output ##1 !thermistor_bias_output
	) else $error("own bias enabled with external pullup");

	a_hot_stays: assert property (
		(state == TFW_ACTIVE && eval_now && !cr_lost && fault == TFW_F_HOT)
		|=> overtemp_flag && !discharge_gate_drive && mode == TFW_ACTIVE
	) else $error("overtemperature not handled");

	a_open_clears: assert property (
		(state == TFW_ACTIVE && eval_now && !cr_lost && fault == TFW_F_NONE)
		|=> !open_flag && !overtemp_flag
	) else $error("open fault not cleared on clean read");

	a_short_down: assert property (
		(state == TFW_ACTIVE && eval_now && !cr_lost && fault == TFW_F_SHORT)
		|=> mode == TFW_SHUTDOWN && short_flag ##1 mode == TFW_SHUTDOWN
	) else $error("short did not shut down");
endmodule : tfw_top

// ==== tb/tfw_pack_model.sv ====
`timescale 1ns/1ps
`include "tfw_regs.svh"
module tfw_pack_model (
	input  wire logic                   clock,    // system clock
	input  wire logic                   reg_en,   // regulator enable
	input  wire logic                   bias,     // own bias on
	input  wire logic                   ext,      // charger bias present
	input  wire logic [`TFW_CODE_W-1:0] level,    // thermistor fraction
	output logic                        reg_good, // regulator good
	output logic [`TFW_CODE_W-1:0]      code      // sense code
);
	logic [1:0] ramp;
	// regulator needs two cycles to come good
	always_ff @(posedge clock) begin
		ramp <= {ramp[0], reg_en};
	end
	assign reg_good = ramp[1] & reg_en;
	// code is a fraction of the bias
	// unbiased pin is dragged to ground by the sink
	assign code = (ext | bias) ? level : 10'h000;
endmodule : tfw_pack_model

// ==== tb/thermistor_fault_and_wake_logic_tb.sv ====
`timescale 1ns/1ps
module thermistor_fault_and_wake_logic_tb;
	import tfw_pkg::*;
	logic       clock = 0, nrst = 0, charger = 0, ret_low = 0, ext = 0;
	logic [9:0] level = 10'h200, code, v;
	logic       reg_en, reg_good, dis_gate, ch_gate, bias, sink, hot, opened, shorted;
	tfw_state_t mode;
	int         bad_count = 0, checked = 0, seed = 5, k;

	always #2.5 clock = ~clock;

	tfw_top #(.CHECK_CYC(20), .SETTLE_CYC(3), .PWRUP_CYC(4)) tfw_top_i (
		.clock(clock), .nrst(nrst), .charger_sense_input(charger),
		.charger_return_input(ret_low), .regulator_output(reg_good),
		.thermistor_sense_input(code), .regulator_enable(reg_en),
		.discharge_gate_drive(dis_gate), .charge_gate_drive(ch_gate),
		.thermistor_bias_output(bias), .sense_sink_enable(sink), .overtemp_flag(hot),
		.open_flag(opened), .short_flag(shorted), .mode(mode));
	tfw_pack_model tfw_pack_model_i (.clock(clock), .reg_en(reg_en), .bias(bias),
		.ext(ext), .level(level), .reg_good(reg_good), .code(code));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic wait_mode(input tfw_state_t m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++) tick(1);
		if (mode !== m) begin
			chk(mode, m);
			wrap_up();
		end
	endtask : wait_mode

	// flags are settled once the sink drops
	task automatic run_check(input logic [9:0] lv);
		level = lv;
		for (int i = 0; i < 40 && sink !== 1'b1; i++) tick(1);
		if (sink !== 1'b1) begin
			chk(sink, 1);
			wrap_up();
		end
		for (int i = 0; i < 40 && sink === 1'b1; i++) tick(1);
		if (sink !== 1'b0) begin
			chk(sink, 0);
			wrap_up();
		end
	endtask : run_check

	// {hot, open, short}; short wins over hot
	function automatic logic [2:0] exp_flags(input logic [9:0] lv);
		if (lv < 10'h020) return 3'b001;
		if (lv > 10'h3C0) return 3'b010;
		if (lv < 10'h100) return 3'b100;
		return 3'b000;
	endfunction : exp_flags

	// sampled mid-cycle, away from the launching edge
	always @(negedge clock) if (nrst) begin
		chk((dis_gate | ch_gate) & (mode != TFW_ACTIVE | ~reg_good), 0);
		chk(bias & (~sink | ext), 0);
	end

	initial begin
		tick(4);
		nrst = 1;
		chk({reg_en, dis_gate, ch_gate, bias, sink, hot, opened, shorted, 6'h00, mode}, 0);
		tick(10);
		chk({reg_en, mode}, 0);
		charger = 1;
		wait_mode(TFW_POWERUP, 5);
		chk({reg_en, dis_gate, ch_gate}, 3'b100);
		wait_mode(TFW_ACTIVE, 20);
		chk({dis_gate, ch_gate}, 2'b11);
		// boundary readings first, then random ones
		for (k = 0; k < 14; k++) begin
			case (k)
				0: v = 10'h100;
				1: v = 10'h020;
				2: v = 10'h3C1;
				3: v = 10'h3C0;
				default: v = 10'h020 + 10'($unsigned($random(seed)) % 961);
			endcase
			run_check(v);
			chk({hot, opened, shorted}, exp_flags(v));
			chk(mode, TFW_ACTIVE);
			chk({dis_gate, ch_gate}, (exp_flags(v) == 0) ? 2'b11 : 2'b00);
		end
		ext = 1;
		run_check(10'h3F0);
		chk(opened, 1);
		ext = 0;
		run_check(10'h01F);
		chk({shorted, reg_en, dis_gate, ch_gate, mode}, {4'b1000, TFW_SHUTDOWN});
		tick(10);
		chk(mode, TFW_SHUTDOWN);
		charger = 0;
		tick(4);
		charger = 1;
		wait_mode(TFW_ACTIVE, 30);
		run_check(10'h000);
		chk(mode, TFW_SHUTDOWN);
		charger = 0;
		tick(4);
		ret_low = 1;
		wait_mode(TFW_POWERUP, 5);
		ret_low = 0;
		wait_mode(TFW_SHUTDOWN, 5);
		chk(reg_en, 0);
		wrap_up();
	end
endmodule : thermistor_fault_and_wake_logic_tb
